// ---- verilog/exit_info_defs.vh ----
// Field layout constants for the exit instruction-information encoder
`ifndef EXIT_INFO_DEFS_VH
`define EXIT_INFO_DEFS_VH

// Register offsets (word addresses on the plain register port)
`define EI_ADDR_W          4
`define EI_OFF_CTRL        4'h0
`define EI_OFF_REGDEST     4'h1
`define EI_OFF_MEMOP       4'h2
`define EI_OFF_STATUS      4'h3
`define EI_OFF_LAST        4'h4

// Control register bits
`define EI_CTRL_LONG_BIT   0
`define EI_CTRL_CLEAR_BIT  1
`define EI_CTRL_W          2
`define EI_CTRL_RESET      2'h0

// Instruction kinds on the decoded-instruction port
`define EI_KIND_W          4
`define EI_K_RAND          4'h0
`define EI_K_SEED          4'h1
`define EI_K_CONTROL_STRUCTURE_CLEAR       4'h2
`define EI_K_PTRLD         4'h3
`define EI_K_PTRST         4'h4
`define EI_K_VMENTER       4'h5
`define EI_K_RSTORS        4'h6
`define EI_K_SAVES         4'h7

// Register-destination layout
`define EI_RD_REG_LSB      3
`define EI_RD_REG_MSB      6
`define EI_RD_SIZE_LSB     11
`define EI_RD_SIZE_MSB     12

// Memory-operand layout
`define EI_MO_SCALE_LSB    0
`define EI_MO_SCALE_MSB    1
`define EI_MO_ASIZE_LSB    7
`define EI_MO_ASIZE_MSB    9
`define EI_MO_MEMREG_BIT   10
`define EI_MO_SEG_LSB      15
`define EI_MO_SEG_MSB      17
`define EI_MO_IDX_LSB      18
`define EI_MO_IDX_MSB      21
`define EI_MO_IDXINV_BIT   22
`define EI_MO_BASE_LSB     23
`define EI_MO_BASE_MSB     26
`define EI_MO_BASEINV_BIT  27

// Encodings
`define EI_SIZE_16         2'h0
`define EI_SIZE_32         2'h1
`define EI_SIZE_64         2'h2
`define EI_ASIZE_16        3'h0
`define EI_ASIZE_32        3'h1
`define EI_ASIZE_64        3'h2
`define EI_SCALE_8         2'h3
`define EI_SEG_LAST        3'h5
`define EI_SEG_DS          3'h3
`define EI_REG_LOW_MAX     4'h7
`define EI_MEM_OPERAND     1'h0
`define EI_WORD_ZERO       32'h00000000

// Status register bits
`define EI_ST_RD_VALID     0
`define EI_ST_MO_VALID     1
`define EI_ST_ADJUSTED     2
`define EI_ST_W            3

`endif

// ---- verilog/exit_info_store.v ----
// Small register store holding the most recent encoded words
`timescale 1ns/1ps
`default_nettype none
`include "exit_info_defs.vh"

module exit_info_store (
   // Clock and control
   input  wire        clock_i,
   input  wire        reset_i,
   input  wire        enable_i,
   // Write side
   input  wire        write_i,
   input  wire [1:0]  write_index_i,
   input  wire [31:0] write_data_i,
   // Read side, registered
   input  wire [1:0]  read_index_i,
   output reg  [31:0] read_data_o
);

   reg [31:0] word_mem [0:3];
   integer    i;

   always @(posedge clock_i) begin
      if (reset_i) begin
         for (i = 0; i < 4; i = i + 1) begin
            word_mem[i] <= `EI_WORD_ZERO;
         end
         read_data_o <= `EI_WORD_ZERO;
      end else if (enable_i) begin
         if (write_i) begin
            word_mem[write_index_i] <= write_data_i;
         end
         read_data_o <= word_mem[read_index_i];
      end
   end

endmodule

`default_nettype wire

// ---- verilog/exit_instruction_info_encoder.v ----
// Encoder of the exit instruction-information word for two layouts
//
// Functional notes
// - Destination register number in bits 6:3
// - Operand size bits 12:11, never three
// - Index scaling in bits 1:0
// - No index: scaling unspecified, bit 22 set
// - Address size bits 9:7, only 0-2
// - Segment bits 17:15, only values 0-5
// - Index register number in bits 21:18
// - Bit 22 flags missing index register
// - Base register number in bits 26:23
// - Bit 27 flags missing base register
//
// The implementer's own choices: the address map and the plain strobed port.
`include "exit_info_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module exit_instruction_info_encoder (
   // Clock, reset, enable
   input  wire                   clock_i,
   input  wire                   reset_i,
   input  wire                   enable_i,
   // Decoded exiting instruction
   input  wire                   exit_valid_i,
   input  wire [`EI_KIND_W-1:0]  exit_kind_i,
   input  wire [3:0]             dest_reg_i,
   input  wire [1:0]             operand_size_i,
   input  wire [1:0]             scale_i,
   input  wire [2:0]             address_size_i,
   input  wire [2:0]             segment_i,
   input  wire                   index_present_i,
   input  wire [3:0]             index_register_number_i,
   input  wire                   base_present_i,
   input  wire [3:0]             base_register_number_i,
   // Encoded word
   output reg                    info_valid_o,
   output reg  [31:0]            info_word_o,
   output reg                    info_is_memory_o,
   // Register port
   input  wire [`EI_ADDR_W-1:0]  reg_addr_i,
   input  wire [31:0]            reg_wdata_i,
   input  wire                   reg_write_i,
   input  wire                   reg_read_i,
   output reg  [31:0]            reg_rdata_o
);

   // Flow states, one-hot
   localparam [2:0] ST_IDLE  = 3'b001;
   localparam [2:0] ST_HOLD  = 3'b010;
   localparam [2:0] ST_CLEAR = 3'b100;

   // Read-path source selection
   localparam [1:0] RD_NONE   = 2'h0;
   localparam [1:0] RD_STORE  = 2'h1;
   localparam [1:0] RD_DIRECT = 2'h2;
   // Word slots in the store
   localparam [1:0] SLOT_REGDEST = 2'h0;
   localparam [1:0] SLOT_MEMOP   = 2'h1;

   reg [2:0]             state_reg;
   reg [2:0]             state_next;
   reg [`EI_CTRL_W-1:0]  ctrl_reg;
   reg [`EI_ST_W-1:0]    status_reg;
   reg [`EI_ST_W-1:0]    status_next;
   reg [31:0]            word_next;
   reg                   is_mem_next;
   reg                   adjusted_next;
   reg                   rd_pending_reg;
   reg [1:0]             rd_sel_reg;
   reg [31:0]            rd_direct_reg;

   wire        long_mode = ctrl_reg[`EI_CTRL_LONG_BIT];
   wire        clear_req = reg_write_i &&
                           (reg_addr_i == `EI_OFF_CTRL) &&
                           reg_wdata_i[`EI_CTRL_CLEAR_BIT];
   wire [31:0] store_rdata;

   // Register numbers above seven exist only with 64-bit support; a
   // narrow core folds them down rather than report a missing register.
   function [3:0] fold_reg;
      input [3:0] r;
      input       wide;
      begin
         if (!wide && (r > `EI_REG_LOW_MAX)) begin
            fold_reg = r & `EI_REG_LOW_MAX;
         end else begin
            fold_reg = r;
         end
      end
   endfunction

   function is_rand_kind;
      input [`EI_KIND_W-1:0] k;
      begin
         is_rand_kind = (k == `EI_K_RAND) || (k == `EI_K_SEED);
      end
   endfunction

   function is_mem_kind;
      input [`EI_KIND_W-1:0] k;
      begin
         is_mem_kind = (k == `EI_K_CONTROL_STRUCTURE_CLEAR) || (k == `EI_K_PTRLD) ||
                       (k == `EI_K_PTRST) || (k == `EI_K_VMENTER) ||
                       (k == `EI_K_RSTORS) || (k == `EI_K_SAVES);
      end
   endfunction

   // Sizes of 16 and 32 bits always pass; 64 needs long mode
   function size_legal;
      input [2:0] s;
      input       wide;
      begin
         size_legal = (s == `EI_ASIZE_16) || (s == `EI_ASIZE_32) ||
                      ((s == `EI_ASIZE_64) && wide);
      end
   endfunction

   // Word construction
   always @* begin
      word_next     = `EI_WORD_ZERO;
      is_mem_next   = 1'b0;
      adjusted_next = 1'b0;
      if (is_rand_kind(exit_kind_i)) begin
         word_next[`EI_RD_REG_MSB:`EI_RD_REG_LSB] =
            fold_reg(dest_reg_i, long_mode);
         if (size_legal({1'b0, operand_size_i}, long_mode)) begin
            word_next[`EI_RD_SIZE_MSB:`EI_RD_SIZE_LSB] =
               operand_size_i;
         end else begin
            // Illegal size requests fall back to 32-bit, never 3
            word_next[`EI_RD_SIZE_MSB:`EI_RD_SIZE_LSB] =
               `EI_SIZE_32;
            adjusted_next = 1'b1;
         end
      end else if (is_mem_kind(exit_kind_i)) begin
         is_mem_next = 1'b1;
         if (index_present_i) begin
            if (scale_i == `EI_SCALE_8 && !long_mode) begin
               word_next[`EI_MO_SCALE_MSB:`EI_MO_SCALE_LSB] =
                  `EI_SIZE_64;
               adjusted_next = 1'b1;
            end else begin
               word_next[`EI_MO_SCALE_MSB:`EI_MO_SCALE_LSB] =
                  scale_i;
            end
            word_next[`EI_MO_IDX_MSB:`EI_MO_IDX_LSB] =
               fold_reg(index_register_number_i, long_mode);
         end
         // Without an index the scale and index fields stay zero
         word_next[`EI_MO_IDXINV_BIT] = !index_present_i;
         if (size_legal(address_size_i, long_mode)) begin
            word_next[`EI_MO_ASIZE_MSB:`EI_MO_ASIZE_LSB] =
               address_size_i;
         end else begin
            word_next[`EI_MO_ASIZE_MSB:`EI_MO_ASIZE_LSB] =
               `EI_ASIZE_32;
            adjusted_next = 1'b1;
         end
         word_next[`EI_MO_MEMREG_BIT] = `EI_MEM_OPERAND;
         // Unused segment codes are replaced by the data segment
         if (segment_i > `EI_SEG_LAST) begin
            word_next[`EI_MO_SEG_MSB:`EI_MO_SEG_LSB] =
               `EI_SEG_DS;
            adjusted_next = 1'b1;
         end else begin
            word_next[`EI_MO_SEG_MSB:`EI_MO_SEG_LSB] =
               segment_i;
         end
         if (base_present_i) begin
            word_next[`EI_MO_BASE_MSB:`EI_MO_BASE_LSB] =
               fold_reg(base_register_number_i, long_mode);
         end
         word_next[`EI_MO_BASEINV_BIT] = !base_present_i;
      end
   end

   wire capture = exit_valid_i &&
                  (is_rand_kind(exit_kind_i) || is_mem_kind(exit_kind_i));

   // A clear wipes the word of the layout captured last; with nothing
   // held it writes nothing, so an older word is never wiped twice
   wire [1:0] clear_slot   = status_reg[`EI_ST_MO_VALID] ? SLOT_MEMOP :
                                                           SLOT_REGDEST;
   wire       clear_word   = clear_req && (status_reg[`EI_ST_RD_VALID] ||
                                           status_reg[`EI_ST_MO_VALID]);
   wire [1:0] capture_slot = is_mem_next ? SLOT_MEMOP : SLOT_REGDEST;
   wire [1:0] read_slot    = (reg_addr_i == `EI_OFF_MEMOP) ? SLOT_MEMOP :
                                                             SLOT_REGDEST;

   // State flow: a held word stands until the next exit or a clear
   always @* begin
      state_next  = state_reg;
      status_next = status_reg;
      case (state_reg)
         ST_IDLE: begin
            if (capture) begin
               state_next = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (clear_req && !capture) begin
               state_next = ST_CLEAR;
            end
         end
         ST_CLEAR: begin
            state_next = capture ? ST_HOLD : ST_IDLE;
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
      // A capture in the same cycle as a clear wins
      if (capture) begin
         status_next[`EI_ST_RD_VALID] = !is_mem_next;
         status_next[`EI_ST_MO_VALID] = is_mem_next;
         status_next[`EI_ST_ADJUSTED] = adjusted_next;
      end else if (clear_req) begin
         status_next = {`EI_ST_W{1'b0}};
      end
   end

   always @(posedge clock_i) begin
      if (reset_i) begin
         state_reg        <= ST_IDLE;
         status_reg       <= {`EI_ST_W{1'b0}};
         ctrl_reg         <= `EI_CTRL_RESET;
         info_valid_o     <= 1'b0;
         info_word_o      <= `EI_WORD_ZERO;
         info_is_memory_o <= 1'b0;
      end else if (enable_i) begin
         state_reg    <= state_next;
         status_reg   <= status_next;
         info_valid_o <= capture;
         if (capture) begin
            info_word_o      <= word_next;
            info_is_memory_o <= is_mem_next;
         end
         if (reg_write_i && reg_addr_i == `EI_OFF_CTRL) begin
            ctrl_reg <= {1'b0, reg_wdata_i[`EI_CTRL_LONG_BIT]};
         end
      end
   end

   // Layout words live in the store: index 0 destination, 1 memory
   exit_info_store i_exit_info_store (
      .clock_i       (clock_i),
      .reset_i       (reset_i),
      .enable_i      (enable_i),
      .write_i       (capture || clear_word),
      .write_index_i (capture ? capture_slot : clear_slot),
      .write_data_i  (capture ? word_next : `EI_WORD_ZERO),
      .read_index_i  (read_slot),
      .read_data_o   (store_rdata)
   );

   // Read path: store words and direct registers, one cycle later
   always @(posedge clock_i) begin
      if (reset_i) begin
         rd_pending_reg <= 1'b0;
         rd_sel_reg     <= RD_NONE;
         rd_direct_reg  <= `EI_WORD_ZERO;
      end else if (enable_i) begin
         rd_pending_reg <= reg_read_i;
         rd_sel_reg     <= RD_NONE;
         rd_direct_reg  <= `EI_WORD_ZERO;
         if (reg_read_i) begin
            case (reg_addr_i)
               `EI_OFF_REGDEST, `EI_OFF_MEMOP: rd_sel_reg <= RD_STORE;
               `EI_OFF_CTRL: begin
                  // The clear bit is never stored, so it reads as zero
                  rd_sel_reg    <= RD_DIRECT;
                  rd_direct_reg <= {30'h00000000, ctrl_reg};
               end
               `EI_OFF_STATUS: begin
                  rd_sel_reg    <= RD_DIRECT;
                  rd_direct_reg <= {29'h00000000, status_reg};
               end
               `EI_OFF_LAST: begin
                  rd_sel_reg    <= RD_DIRECT;
                  rd_direct_reg <= info_word_o;
               end
               default: rd_sel_reg <= RD_NONE;
            endcase
         end
      end
   end

   always @* begin
      case (rd_sel_reg)
         RD_STORE:  reg_rdata_o = store_rdata;
         RD_DIRECT: reg_rdata_o = rd_direct_reg;
         default:   reg_rdata_o = `EI_WORD_ZERO;
      endcase
      // Zero outside the answer cycle keeps the port quiet between reads
      if (!rd_pending_reg) begin
         reg_rdata_o = `EI_WORD_ZERO;
      end
   end

endmodule

`default_nettype wire

// ---- verification/exit_instruction_info_encoder_chk.sv ----
// Assertion checker for the exit instruction-information encoder
`include "exit_info_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module exit_instruction_info_encoder_chk (
   // Clock, reset, enable
   input wire logic                  clock_i,
   input wire logic                  reset_i,
   input wire logic                  enable_i,
   // Decoded instruction
   input wire logic                  exit_valid_i,
   input wire logic [`EI_KIND_W-1:0] exit_kind_i,
   input wire logic [3:0]            dest_reg_i,
   input wire logic [1:0]            operand_size_i,
   input wire logic [1:0]            scale_i,
   input wire logic [2:0]            address_size_i,
   input wire logic [2:0]            segment_i,
   input wire logic                  index_present_i,
   input wire logic [3:0]            index_register_number_i,
   input wire logic                  base_present_i,
   input wire logic [3:0]            base_register_number_i,
   // Encoded word
   input wire logic                  info_valid_o,
   input wire logic [31:0]           info_word_o,
   input wire logic                  info_is_memory_o
);
   wire logic cap = enable_i && exit_valid_i && exit_kind_i <= `EI_K_SAVES;
   wire logic rd = cap && exit_kind_i <= `EI_K_SEED;
   wire logic mem = cap && !rd;
   default clocking @(posedge clock_i); endclocking
   default disable iff (reset_i);
   // Low three bits survive the fold applied outside long mode
   AST_RD_REG: assert property (rd |=> !info_is_memory_o &&
      info_word_o[5:3] == $past(dest_reg_i[2:0])) else $error("dest reg");
   AST_RD_SIZE: assert property (rd |=> info_word_o[12:11] != 2'h3 &&
      ($past(operand_size_i) > 2'h1 ||
       info_word_o[12:11] == $past(operand_size_i))) else $error("op size");
   AST_SCALE: assert property (mem && index_present_i && scale_i < 2'h3
      |=> info_word_o[1:0] == $past(scale_i)) else $error("scale");
   AST_ASIZE: assert property (mem |=> info_word_o[9:7] <= 3'h2 &&
      ($past(address_size_i) > 3'h1 ||
       info_word_o[9:7] == $past(address_size_i))) else $error("addr size");
   AST_SEG: assert property (mem |=> info_word_o[17:15] <= 3'h5 &&
      ($past(segment_i) > 3'h5 ||
       info_word_o[17:15] == $past(segment_i))) else $error("segment");
   AST_IDX: assert property (mem && index_present_i |=>
      info_word_o[20:18] == $past(index_register_number_i[2:0]))
      else $error("index reg");
   AST_IDXINV: assert property (mem |=>
      info_word_o[22] == !$past(index_present_i)) else $error("index flag");
   AST_BASE: assert property (mem && base_present_i |=>
      info_word_o[25:23] == $past(base_register_number_i[2:0]))
      else $error("base reg");
   AST_BASEINV: assert property (mem |=>
      info_word_o[27] == !$past(base_present_i)) else $error("base flag");
   AST_MEMBIT: assert property (mem |=> info_is_memory_o &&
      !info_word_o[10]) else $error("memory bit");
   AST_PULSE: assert property (enable_i |=> info_valid_o == $past(cap))
      else $error("valid pulse");
   COV_RD: cover property (rd ##1 info_valid_o);
   COV_NOIDX: cover property (mem && !index_present_i);
   COV_NOBASE: cover property (mem && !base_present_i ##1 mem);
endmodule
`default_nettype wire

// ---- verification/test_exit_instruction_info_encoder.sv ----
// Self-checking bench for the exit instruction-information encoder
`include "exit_info_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module test_exit_instruction_info_encoder;
   logic        clock_i = 1'b0, reset_i = 1'b1, enable_i = 1'b0;
   logic        exit_valid_i = 1'b0, index_present_i = 1'b0;
   logic        base_present_i = 1'b0, reg_write_i = 1'b0;
   logic        reg_read_i = 1'b0, info_valid_o, info_is_memory_o;
   logic [3:0]  exit_kind_i = 4'h0, dest_reg_i = 4'h0, reg_addr_i = 4'h0;
   logic [3:0]  index_register_number_i = 4'h0;
   logic [3:0]  base_register_number_i = 4'h0;
   logic [1:0]  operand_size_i = 2'h0, scale_i = 2'h0;
   logic [2:0]  address_size_i = 3'h0, segment_i = 3'h0;
   logic [31:0] reg_wdata_i = 32'h00000000, info_word_o, reg_rdata_o;
   logic [3:0]  f_dr = 4'h0, f_ix = 4'h0, f_bx = 4'h0;
   logic [1:0]  f_os = 2'h0, f_sc = 2'h0;
   logic [2:0]  f_as = 3'h0, f_sg = 3'h0;
   logic        f_ip = 1'b0, f_bp = 1'b0, long_mode = 1'b0;
   integer      n_fail = 0, n_checks = 0, cycles = 0, seed = 93, i;
   exit_instruction_info_encoder i_exit_instruction_info_encoder (.*);
   always #10 clock_i = ~clock_i;
   always @(posedge clock_i) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_fail = n_fail + 1;
         tally_and_finish;
      end
   end
   task tally_and_finish;
      begin
         $display("TB counts: checks %0d, mismatches %0d", n_checks, n_fail);
         if (n_fail == 0 && n_checks > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   task chk(input logic [31:0] got, e, m, input string what);
      begin
         n_checks = n_checks + 1;
         if ((got & m) !== (e & m)) begin
            n_fail = n_fail + 1;
            $display("Error at %0t: %s got %h want %h", $time, what, got, e);
         end
      end
   endtask
   function automatic [3:0] fold(input logic [3:0] r);
      fold = long_mode ? r : {1'b0, r[2:0]};
   endfunction
   function automatic [31:0] exp_word();
      logic [31:0] w;
      begin
         w = 32'h00000000;
         if (exit_kind_i <= `EI_K_SEED) begin
            w[6:3] = fold(dest_reg_i);
            w[12:11] = (!long_mode && operand_size_i == 2'h2) ?
                       2'h1 : operand_size_i;
         end else begin
            w[1:0] = (!long_mode && scale_i == 2'h3) ? 2'h2 : scale_i;
            w[9:7] = (!long_mode && address_size_i == 3'h2) ?
                     3'h1 : address_size_i;
            w[17:15] = segment_i;
            w[21:18] = fold(index_register_number_i);
            w[22] = !index_present_i;
            w[26:23] = fold(base_register_number_i);
            w[27] = !base_present_i;
         end
         exp_word = w;
      end
   endfunction
   // Undefined bits, and fields whose register is absent, are masked out
   function automatic [31:0] exp_mask();
      if (exit_kind_i <= `EI_K_SEED)
         exp_mask = 32'h00001878;
      else
         exp_mask = 32'h08438780 | (index_present_i ? 32'h003C0003 : 32'h0)
                    | (base_present_i ? 32'h07800000 : 32'h0);
   endfunction
   // Drives one request and checks the one launched a cycle before
   task step(input logic en, v, input logic [3:0] k);
      logic        c, pe;
      logic [31:0] e, m;
      begin
         @(posedge clock_i);
         pe = enable_i;
         c = enable_i && exit_valid_i && exit_kind_i <= `EI_K_SAVES;
         e = exp_word();
         m = exp_mask();
         e[31] = exit_kind_i > `EI_K_SEED;
         enable_i <= en;
         exit_valid_i <= v;
         exit_kind_i <= k;
         dest_reg_i <= f_dr;
         operand_size_i <= f_os;
         scale_i <= f_sc;
         address_size_i <= f_as;
         segment_i <= f_sg;
         index_present_i <= f_ip;
         index_register_number_i <= f_ix;
         base_present_i <= f_bp;
         base_register_number_i <= f_bx;
         @(negedge clock_i);
         if (pe)
            chk({31'h0, info_valid_o}, {31'h0, c}, 32'h1, "valid");
         if (c)
            chk(info_word_o, e, m, "word");
         if (c)
            chk({31'h0, info_is_memory_o}, {31'h0, e[31]}, 32'h1, "kind");
      end
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d);
      begin
         @(posedge clock_i);
         reg_write_i <= 1'b1;
         reg_addr_i <= a;
         reg_wdata_i <= d;
         @(posedge clock_i);
         reg_write_i <= 1'b0;
      end
   endtask
   task rdchk(input logic [3:0] a, input logic [31:0] e, m);
      begin
         @(posedge clock_i);
         reg_read_i <= 1'b1;
         reg_addr_i <= a;
         @(posedge clock_i);
         reg_read_i <= 1'b0;
         @(negedge clock_i);
         chk(reg_rdata_o, e, m, "register read");
      end
   endtask
   initial begin
      repeat (8) @(posedge clock_i);
      reset_i <= 1'b0;
      enable_i <= 1'b1;
      wr(`EI_OFF_CTRL, 32'h00000001);
      long_mode = 1'b1;
      rdchk(`EI_OFF_CTRL, 32'h00000001, 32'h00000003);
      rdchk(4'hF, 32'h00000000, 32'hFFFFFFFF);
      $display("TB test registers done");
      f_ip = 1'b1;
      f_bp = 1'b1;
      for (i = 0; i < 10; i = i + 1) begin
         f_dr = i + 6;
         f_ix = i + 3;
         f_bx = 15 - i;
         f_sg = i % 6;
         step(1'b1, 1'b1, i);
      end
      $display("TB test kinds done");
      f_ip = 1'b0;
      f_bp = 1'b0;
      f_sc = 2'h3;
      f_as = 3'h2;
      f_sg = 3'h5;
      step(1'b1, 1'b1, `EI_K_SAVES);
      f_dr = 4'hF;
      f_os = 2'h2;
      step(1'b1, 1'b1, `EI_K_SEED);
      step(1'b1, 1'b0, 4'h0);
      step(1'b1, 1'b0, 4'h0);
      rdchk(`EI_OFF_MEMOP, 32'h08428100, 32'h08438780);
      rdchk(`EI_OFF_REGDEST, 32'h00001078, 32'h00001878);
      rdchk(`EI_OFF_STATUS, 32'h00000001, 32'h00000007);
      $display("TB test corners done");
      for (i = 0; i < 300; i = i + 1) begin
         f_dr = $random(seed);
         f_os = {$random(seed)} % 3;
         f_sc = $random(seed);
         f_as = {$random(seed)} % 3;
         f_sg = {$random(seed)} % 6;
         f_ip = $random(seed);
         f_ix = $random(seed);
         f_bp = $random(seed);
         f_bx = $random(seed);
         step(({$random(seed)} % 8) != 0, $random(seed), {$random(seed)} % 10);
      end
      step(1'b1, 1'b0, 4'h0);
      $display("TB test random done");
      wr(`EI_OFF_CTRL, 32'h00000000);
      long_mode = 1'b0;
      f_dr = 4'hC;
      f_os = 2'h2;
      f_sc = 2'h3;
      f_ip = 1'b1;
      f_bp = 1'b1;
      step(1'b1, 1'b1, `EI_K_RAND);
      step(1'b1, 1'b1, `EI_K_PTRLD);
      step(1'b1, 1'b0, 4'h0);
      step(1'b1, 1'b0, 4'h0);
      rdchk(`EI_OFF_STATUS, 32'h00000006, 32'h00000007);
      wr(`EI_OFF_CTRL, 32'h00000002);
      rdchk(`EI_OFF_STATUS, 32'h00000000, 32'h00000007);
      rdchk(`EI_OFF_MEMOP, 32'h00000000, 32'hFFFFFFFF);
      rdchk(`EI_OFF_REGDEST, 32'h00000820, 32'h00001878);
      rdchk(`EI_OFF_CTRL, 32'h00000000, 32'h00000003);
      $display("TB test short mode done");
      tally_and_finish;
   end
endmodule
bind exit_instruction_info_encoder exit_instruction_info_encoder_chk i_chk (.*);
`default_nettype wire
